// File: include/wdt_pkg.sv
// constants and types shared by the watchdog timer unit
package wdt_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_MODE = 12'h000;
  localparam logic [11:0] OFF_RELOAD = 12'h004;
  localparam logic [11:0] OFF_FEED = 12'h008;
  localparam logic [11:0] OFF_COUNT = 12'h00c;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int BIT_RUN_EN = 0;
  localparam int BIT_RST_EN = 1;
  localparam int BIT_TOF = 2;
  localparam int BIT_IRQF = 3;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RESET = 32'h0000_00ff;
  localparam logic [31:0] COUNT_RESET = 32'h0000_00ff;
  localparam logic [31:0] RELOAD_MIN = 32'h0000_00ff;

  // ----------------------------------------------------------------
  // feed sequence and prescaler
  // ----------------------------------------------------------------
  localparam logic [7:0] FEED_FIRST = 8'haa;
  localparam logic [7:0] FEED_SECOND = 8'h55;
  localparam int PRESCALE_DIV = 4;
  localparam int PRESCALE_W = 2;

  typedef enum logic [1:0] {
    FEED_IDLE = 2'b00,
    FEED_HALF = 2'b01
  } feed_state_t;

  typedef struct packed {
    logic irq_flag;
    logic tof;
    logic rst_en;
    logic run_en;
  } mode_bits_t;

endpackage : wdt_pkg

// File: hdl/watchdog_timer_unit.sv
// watchdog timer unit with prescaler, feed sequence and apb registers
`timescale 1ns/1ps
// Function
// - count clock divided by fixed four, prescaler drives 32-bit counter
// - counter decrements by one on every prescaled tick while armed and above zero
// - reload values below 0xff are stored as 0xff
// - writing 0xaa then 0x55 to feed reloads counter and, with run enable set, starts it
// - software cannot clear enables; only reset or time-out clears them
// - bad or incomplete feed sequence faults when watchdog is running
// - underflow in reset mode requests a full chip reset
// - time-out flag sticks until software clears it
// - bus clock for registers and counting, count clock edges sampled as ticks
// - mode and reload writes reach counting logic on the next bus clock
// - count captured on count tick, then copied to bus readout
// - read-only counter readout at 0x00c, reset 0xff
// - read-write reload register at 0x004, reset 0xff
// - read-write mode register at 0x000, reset zero
// - mode bits: run enable, reset enable, time-out flag, irq flag
// - underflow in interrupt mode sets irq flag and raises irq
// - wrong access after first feed faults in second bus cycle after
// - enable alone does not arm; feed errors ignored until armed
module watchdog_timer_unit
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watchdog count clock, sampled as an ordinary input
  input wire logic count_clock,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system outputs
  output logic chip_reset_req,
  output logic wdt_irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction : hit

  logic acc, wr, rd;
  logic wr_mode, wr_reload, wr_feed, rd_feed;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign wr_mode = wr & hit(paddr, OFF_MODE);
  assign wr_reload = wr & hit(paddr, OFF_RELOAD);
  assign wr_feed = wr & hit(paddr, OFF_FEED);
  assign rd_feed = rd & hit(paddr, OFF_FEED);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mode_bits_t mode_r;
  logic [31:0] reload_r, count_r, snap_r, readout_r, prdata_r;
  logic [PRESCALE_W-1:0] pre_r;
  logic cc_s1_r, cc_s2_r, cc_s3_r;
  logic armed_r, bad_d1_r, rst_pulse_r, cap_r;
  feed_state_t feed_r, feed_nxt;
  logic cc_edge, tick, feed_done, bad_acc, tmo;

  // ----------------------------------------------------------------
  // count clock sampling and prescaler
  // ----------------------------------------------------------------
  // only the second stage looks at the first one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cc_s1_r <= 1'b0;
      cc_s2_r <= 1'b0;
      cc_s3_r <= 1'b0;
    end else begin
      cc_s1_r <= count_clock;
      cc_s2_r <= cc_s1_r;
      cc_s3_r <= cc_s2_r;
    end
  end

  assign cc_edge = cc_s2_r & ~cc_s3_r;

  // restarted on each feed so every interval is whole quarters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= '0;
    end else if (feed_done) begin
      pre_r <= '0;
    end else if (cc_edge) begin
      pre_r <= pre_r + 1'b1;
    end
  end

  assign tick = cc_edge &&
    (pre_r == PRESCALE_W'(PRESCALE_DIV - 1));

  // ----------------------------------------------------------------
  // feed sequence
  // ----------------------------------------------------------------
  always_comb begin
    feed_nxt = feed_r;
    bad_acc = 1'b0;
    feed_done = 1'b0;
    case (feed_r)
      FEED_IDLE: begin
        if (wr_feed && pwdata[7:0] == FEED_FIRST) begin
          feed_nxt = FEED_HALF;
        end
      end
      FEED_HALF: begin
        if (wr_feed && pwdata[7:0] == FEED_SECOND) begin
          feed_done = 1'b1;
          feed_nxt = FEED_IDLE;
        end else if (acc && !rd_feed) begin
          bad_acc = 1'b1;
          feed_nxt = FEED_IDLE;
        end
      end
      default: feed_nxt = FEED_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      feed_r <= FEED_IDLE;
    end else begin
      feed_r <= feed_nxt;
    end
  end

  // fault delayed one cycle, so the reset lands in the second cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bad_d1_r <= 1'b0;
    end else begin
      bad_d1_r <= bad_acc & armed_r;
    end
  end

  // ----------------------------------------------------------------
  // arming and time-out
  // ----------------------------------------------------------------
  assign tmo = (armed_r && tick && count_r == '0) || bad_d1_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_r <= 1'b0;
    end else if (tmo) begin
      armed_r <= 1'b0;
    end else if (feed_done && mode_r.run_en) begin
      armed_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= mode_bits_t'(MODE_RESET[3:0]);
    end else begin
      if (tmo) begin
        mode_r.run_en <= 1'b0;
        mode_r.rst_en <= 1'b0;
      end else if (wr_mode) begin
        mode_r.run_en <= mode_r.run_en | pwdata[BIT_RUN_EN];
        mode_r.rst_en <= mode_r.rst_en | pwdata[BIT_RST_EN];
      end
      // set wins over a software clear in the same cycle
      if (tmo) begin
        mode_r.tof <= 1'b1;
      end else if (wr_mode && !pwdata[BIT_TOF]) begin
        mode_r.tof <= 1'b0;
      end
      if (tmo && !mode_r.rst_en) begin
        mode_r.irq_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_pulse_r <= 1'b0;
    end else begin
      rst_pulse_r <= tmo & mode_r.rst_en;
    end
  end

  assign chip_reset_req = rst_pulse_r;
  assign wdt_irq = mode_r.irq_flag;

  // ----------------------------------------------------------------
  // reload register and counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reload_r <= RELOAD_RESET;
    end else if (wr_reload) begin
      reload_r <= (pwdata < RELOAD_MIN) ? RELOAD_MIN : pwdata;
    end
  end

  // single clock here, so a reload write is seen at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= COUNT_RESET;
    end else if (feed_done) begin
      count_r <= reload_r;
    end else if (armed_r && tick && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // readout capture
  // ----------------------------------------------------------------
  // two stages keep the bus view stable between count ticks
  // capture a cycle after the count moves, so the view is not a tick old
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_r <= 1'b0;
      snap_r <= COUNT_RESET;
      readout_r <= COUNT_RESET;
    end else begin
      cap_r <= tick | feed_done;
      if (cap_r) begin
        snap_r <= count_r;
      end
      readout_r <= snap_r;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (hit(paddr, OFF_MODE)) begin
        prdata_r <= {28'h0000000, mode_r};
      end else if (hit(paddr, OFF_RELOAD)) begin
        prdata_r <= reload_r;
      end else if (hit(paddr, OFF_COUNT)) begin
        prdata_r <= readout_r;
      end else begin
        prdata_r <= '0;
      end
    end
  end

  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_min_reload: assert property (@(posedge clk) disable iff (!rstn)
    wr_reload && pwdata < RELOAD_MIN |=> reload_r == RELOAD_MIN)
    else $error("reload below minimum not clamped");

  a_feed_loads: assert property (@(posedge clk) disable iff (!rstn)
    feed_done |=> count_r == $past(reload_r))
    else $error("feed did not reload counter");

  a_enable_sticky: assert property (@(posedge clk) disable iff (!rstn)
    mode_r.run_en && !tmo |=> mode_r.run_en)
    else $error("run enable cleared without time-out");

  a_fault_second: assert property (@(posedge clk) disable iff (!rstn)
    bad_acc && armed_r |-> ##2 (chip_reset_req || wdt_irq))
    else $error("feed fault not acted on in second cycle");

  a_reset_mode: assert property (@(posedge clk) disable iff (!rstn)
    tmo && mode_r.rst_en |=> chip_reset_req)
    else $error("reset mode time-out gave no reset");

  a_irq_mode: assert property (@(posedge clk) disable iff (!rstn)
    tmo && !mode_r.rst_en |=> wdt_irq && !chip_reset_req)
    else $error("interrupt mode time-out wrong");

  a_tof_holds: assert property (@(posedge clk) disable iff (!rstn)
    mode_r.tof && !wr_mode |=> mode_r.tof)
    else $error("time-out flag lost");

  a_decrement: assert property (@(posedge clk) disable iff (!rstn)
    armed_r && tick && count_r != '0 && !feed_done
    |=> count_r == $past(count_r) - 32'h0000_0001)
    else $error("counter did not step down by one");

  a_not_armed: assert property (@(posedge clk) disable iff (!rstn)
    bad_acc && !armed_r |=> !tmo)
    else $error("time-out while not armed");

  a_readout_path: assert property (@(posedge clk) disable iff (!rstn)
    tick && !feed_done |-> ##3 readout_r == $past(count_r, 2))
    else $error("readout did not follow captured count");

  a_prescale: assert property (@(posedge clk) disable iff (!rstn)
    tick |-> cc_edge && pre_r == 2'h3)
    else $error("tick not on fourth count edge");

endmodule : watchdog_timer_unit

// File: dv/apb_host_model.sv
// apb master model standing in for the processor software
`timescale 1ns/1ps
module apb_host_model (
  // bus clock
  input wire logic clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // one setup and one access phase, held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(negedge clk);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
    // released lines must not keep the last value
    pwrite = ~wr;
    paddr = ~a;
    pwdata = ~d;
  endtask : xfer
endmodule : apb_host_model

// File: dv/watchdog_timer_unit_bench.sv
// self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
module watchdog_timer_unit_bench;
  import wdt_pkg::*;
  logic clk, rstn, count_clock, psel, penable, pwrite, pready, pslverr;
  logic chip_reset_req, wdt_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fails, comparisons, edges, pulses, first, n;

  watchdog_timer_unit watchdog_timer_unit_i (.clk(clk), .rstn(rstn),
    .count_clock(count_clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_reset_req(chip_reset_req),
    .wdt_irq(wdt_irq));
  apb_host_model apb_host_model_i (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready));

  // ----------------------------------------------------------------
  // clocks, edge counting and reporting
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // count clock offset so its edges never meet a bus clock edge
  initial begin
    count_clock = 1'b0;
    #3;
    forever #40 count_clock = ~count_clock;
  end
  always @(posedge count_clock) edges++;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb_host_model_i.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(string what, logic [11:0] a, logic [31:0] exp);
    apb_host_model_i.xfer(1'b0, a, 32'h0000_0000, q);
    check(what, q, exp);
  endtask : rd_chk

  task automatic do_reset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
  endtask : do_reset

  // feed aligned just after a count clock edge, edge counter restarted
  task automatic feed();
    wr(OFF_FEED, {24'h0, FEED_FIRST});
    @(posedge count_clock);
    wr(OFF_FEED, {24'h0, FEED_SECOND});
    edges = 0;
  endtask : feed

  // watch for the reset pulse after an access; index of first high cycle
  task automatic watch_pulse();
    first = -1;
    pulses = 0;
    for (int i = 0; i < 6; i++) begin
      if (chip_reset_req === 1'b1) begin
        pulses++;
        if (first < 0) first = i;
      end
      @(negedge clk);
    end
  endtask : watch_pulse

  // a hang is cut short well after the longest interval test
  initial begin
    #400000;
    fails++;
    conclude();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    fails = 0;
    comparisons = 0;
    edges = 0;
    do_reset();
    rd_chk("mode reset", OFF_MODE, MODE_RESET);
    rd_chk("reload reset", OFF_RELOAD, RELOAD_RESET);
    rd_chk("count reset", OFF_COUNT, COUNT_RESET);
    rd_chk("feed read", OFF_FEED, 32'h0000_0000);
    rd_chk("unmapped read", 12'h010, 32'h0000_0000);
    check("no bus error", pslverr, 1'b0);
    check("bus ready", pready, 1'b1);
    wr(OFF_COUNT, 32'h0000_1234);
    rd_chk("count write ignored", OFF_COUNT, COUNT_RESET);
    wr(OFF_RELOAD, 32'h0000_0010);
    rd_chk("reload floor", OFF_RELOAD, RELOAD_MIN);
    $display("test registers done");

    // interrupt mode: enable alone does not arm, then full interval
    wr(OFF_MODE, 32'h0000_0001);
    wr(OFF_MODE, 32'h0000_0000);
    rd_chk("run enable kept", OFF_MODE, 32'h0000_0001);
    wr(OFF_FEED, {24'h0, FEED_FIRST});
    wr(OFF_RELOAD, 32'h0000_0010);
    repeat (4) @(negedge clk);
    check("irq before arming", wdt_irq, 1'b0);
    feed();
    n = 0;
    while (wdt_irq !== 1'b1 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    check("edges to time-out", edges, 32'd1024);
    check("irq level", wdt_irq, 1'b1);
    check("no chip reset", chip_reset_req, 1'b0);
    rd_chk("mode after irq", OFF_MODE, 32'h0000_000c);
    wr(OFF_MODE, 32'h0000_0000);
    rd_chk("flag cleared", OFF_MODE, 32'h0000_0008);
    $display("test interrupt mode done");

    // reset mode: countdown, refeed, then a broken feed sequence
    do_reset();
    check("irq after reset", wdt_irq, 1'b0);
    wr(OFF_RELOAD, 32'h0000_1234);
    rd_chk("reload value", OFF_RELOAD, 32'h0000_1234);
    wr(OFF_MODE, 32'h0000_0003);
    feed();
    repeat (12) @(posedge count_clock);
    repeat (5) @(posedge clk);
    rd_chk("count after three", OFF_COUNT, 32'h0000_1231);
    wr(OFF_FEED, {24'h0, FEED_FIRST});
    rd_chk("feed read mid", OFF_FEED, 32'h0000_0000);
    @(posedge count_clock);
    wr(OFF_FEED, {24'h0, FEED_SECOND});
    repeat (4) @(posedge count_clock);
    repeat (5) @(posedge clk);
    rd_chk("count after refeed", OFF_COUNT, 32'h0000_1233);
    wr(OFF_FEED, {24'h0, FEED_FIRST});
    wr(OFF_RELOAD, 32'h0000_1234);
    watch_pulse();
    check("pulse cycle", first, 32'd1);
    check("pulse count", pulses, 32'd1);
    rd_chk("mode after fault", OFF_MODE, 32'h0000_0004);
    check("irq in reset mode", wdt_irq, 1'b0);
    $display("test reset mode done");
    conclude();
  end
endmodule : watchdog_timer_unit_bench
